// ===== src/ir_mod_pkg.sv
package ir_mod_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] ACTIVE_PERIOD_IDX    = 6'h00;
	localparam logic [5:0] INACTIVE_PERIOD_IDX  = 6'h01;
	localparam logic [5:0] PULSE_COUNT_LOW_IDX  = 6'h02;
	localparam logic [5:0] MODULATOR_CONTROL_IDX = 6'h03;
	localparam logic [5:0] PULSE_COUNT_HIGH_IDX = 6'h04;
	localparam logic [5:0] IRQ_STATUS_IDX       = 6'h05;
	localparam logic [5:0] IRQ_MASK_IDX         = 6'h06;
	localparam logic [5:0] ENGINE_STATE_IDX     = 6'h07;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTL_HF_BIT    = 0;
	localparam int CTL_LONG_BIT  = 1;
	localparam int CTL_PWM_BIT   = 2;
	localparam int CTL_RINT_BIT  = 3;
	localparam int CTL_WRES_BIT  = 4;
	localparam int IRQ_DONE_BIT  = 0;
	localparam int COUNT_HIGH_W  = 2;
	localparam int COUNT_LOW_W   = 8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PERIOD_RESET     = 8'h00;
	localparam logic [7:0] COUNT_LOW_RESET  = 8'h00;
	localparam logic [1:0] COUNT_HIGH_RESET = 2'h0;
	localparam logic [2:0] CONTROL_RESET    = 3'h0;
	localparam logic       MASK_RESET       = 1'b1;

	// ------------------------------------------------------------
	// Timing: each phase lasts register value plus this many cycles
	// ------------------------------------------------------------
	localparam logic [8:0] PHASE_EXTRA_CYCLES = 9'h002;
	localparam int         HF_DIV_W           = 2;

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	typedef enum logic [2:0] {
		PHASE_IDLE     = 3'b001,
		PHASE_ACTIVE   = 3'b010,
		PHASE_INACTIVE = 3'b100
	} phase_type;

endpackage

// ===== src/pulse_timer.sv
`timescale 1ns/1ps
module pulse_timer import ir_mod_pkg::*; #(
	parameter int WIDTH = 9
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             run,
	output logic                  expired
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} timer_state_type;

	timer_state_type s_q;
	timer_state_type s_d;

	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.count = load_value;
		end else if (run && s_q.count != '0) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expired = run && (s_q.count == '0);

endmodule // pulse_timer

// ===== src/pulse_counter.sv
`timescale 1ns/1ps
module pulse_counter import ir_mod_pkg::*; #(
	parameter int WIDTH = 10
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             dec,
	output logic [WIDTH-1:0]      count,
	output logic                  last
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} counter_state_type;

	counter_state_type s_q;
	counter_state_type s_d;

	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.count = load_value;
		end else if (dec && s_q.count != '0) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Zero loaded counts as one pulse, so a train never wraps
	assign count = s_q.count;
	assign last  = (s_q.count <= WIDTH'(1));

endmodule // pulse_counter

// ===== src/ir_pulse_train_modulator.sv
`timescale 1ns/1ps
module ir_pulse_train_modulator import ir_mod_pkg::*; #(
	parameter int ADDR_W  = 8,
	parameter int COUNT_W = 10,
	parameter int TIMER_W = 9
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   ir_pulse_out,
	output logic                   modulator_done_irq,
	output logic                   watchdog_kick
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0]   aw_addr;
		logic                aw_held;
		logic [7:0]          w_data;
		logic                w_lane0;
		logic                w_held;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [1:0]          rresp;
		logic [31:0]         rdata;
		logic [7:0]          active_period;
		logic [7:0]          inactive_period;
		logic [7:0]          count_low;
		logic [1:0]          count_high;
		logic [2:0]          control;
		logic                done_flag;
		logic                done_mask;
		phase_type           phase;
		logic [HF_DIV_W-1:0] hf_div;
		logic                out;
		logic                irq;
		logic                kick;
	} state_type;

	state_type s_q;
	state_type s_d;

	logic               tmr_load;
	logic [TIMER_W-1:0] tmr_value;
	logic               tmr_expired;
	logic               cnt_load;
	logic               cnt_dec;
	logic [COUNT_W-1:0] cnt_value;
	logic               cnt_last;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
		return addr == ADDR_W'({idx, 2'b00});
	endfunction

	function automatic logic known_reg(input logic [ADDR_W-1:0] addr);
		return addr[1:0] == 2'b00 && addr[ADDR_W-1:2] <= (ADDR_W-2)'(ENGINE_STATE_IDX);
	endfunction

	// Phase length register value plus the fixed extra; the timer
	// spends one cycle at zero, hence the minus one
	function automatic logic [TIMER_W-1:0] phase_load(input logic [7:0] period);
		return TIMER_W'(period) + TIMER_W'(PHASE_EXTRA_CYCLES) - TIMER_W'(1);
	endfunction

	// ------------------------------------------------------------
	// Timing engines
	// ------------------------------------------------------------
	pulse_timer #(
		.WIDTH      (TIMER_W)
	) u_timer (
		.clock      (clock),
		.rst_n      (rst_n),
		.load       (tmr_load),
		.load_value (tmr_value),
		.run        (s_q.phase != PHASE_IDLE),
		.expired    (tmr_expired)
	);

	pulse_counter #(
		.WIDTH      (COUNT_W)
	) u_counter (
		.clock      (clock),
		.rst_n      (rst_n),
		.load       (cnt_load),
		.load_value ({s_q.count_high, s_q.w_data}),
		.dec        (cnt_dec),
		.count      (cnt_value),
		.last       (cnt_last)
	);

	// ------------------------------------------------------------
	// Bus handshakes
	// ------------------------------------------------------------
	// Holding registers free only once the response is gone keeps one write in flight
	assign awready = !s_q.aw_held && !s_q.bvalid;
	assign wready  = !s_q.w_held && !s_q.bvalid;
	assign arready = !s_q.rvalid;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic       do_write;
		logic       lane0;
		logic       start;
		logic       set_done;
		logic       clr_done;
		logic       hf;
		logic       long_pulse;
		logic       pwm;

		s_d        = s_q;
		do_write   = 1'b0;
		lane0      = 1'b0;
		start      = 1'b0;
		set_done   = 1'b0;
		clr_done   = 1'b0;
		hf         = s_q.control[CTL_HF_BIT];
		long_pulse = s_q.control[CTL_LONG_BIT];
		pwm        = s_q.control[CTL_PWM_BIT];
		tmr_load   = 1'b0;
		tmr_value  = '0;
		cnt_load   = 1'b0;
		cnt_dec    = 1'b0;
		s_d.kick   = 1'b0;

		// Write address and data, taken in either order
		if (awvalid && awready) begin
			s_d.aw_addr = awaddr;
			s_d.aw_held = 1'b1;
		end
		if (wvalid && wready) begin
			s_d.w_data  = wdata[7:0];
			s_d.w_lane0 = wstrb[0];
			s_d.w_held  = 1'b1;
		end
		if (bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end

		if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
			do_write    = 1'b1;
			lane0       = s_q.w_lane0;
			s_d.aw_held = 1'b0;
			s_d.w_held  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = known_reg(s_q.aw_addr) ? RESP_OKAY : RESP_DECERR;
		end

		// Register writes; only byte lane 0 carries data
		if (do_write && lane0) begin
			if (reg_hit(s_q.aw_addr, ACTIVE_PERIOD_IDX)) begin
				s_d.active_period = s_q.w_data;
			end
			if (reg_hit(s_q.aw_addr, INACTIVE_PERIOD_IDX)) begin
				s_d.inactive_period = s_q.w_data;
			end
			if (reg_hit(s_q.aw_addr, PULSE_COUNT_HIGH_IDX)) begin
				s_d.count_high = s_q.w_data[COUNT_HIGH_W-1:0];
			end
			if (reg_hit(s_q.aw_addr, PULSE_COUNT_LOW_IDX)) begin
				s_d.count_low = s_q.w_data;
				// Ignored while busy or while the previous done is unserviced
				start = (s_q.phase == PHASE_IDLE) && !s_q.done_flag;
			end
			if (reg_hit(s_q.aw_addr, MODULATOR_CONTROL_IDX)) begin
				s_d.control = s_q.w_data[2:0];
				s_d.kick    = s_q.w_data[CTL_WRES_BIT];
				clr_done    = s_q.w_data[CTL_RINT_BIT];
			end
			if (reg_hit(s_q.aw_addr, IRQ_STATUS_IDX) && s_q.w_data[IRQ_DONE_BIT]) begin
				clr_done = 1'b1;
			end
			if (reg_hit(s_q.aw_addr, IRQ_MASK_IDX)) begin
				s_d.done_mask = s_q.w_data[IRQ_DONE_BIT];
			end
		end

		// Reads
		if (rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = known_reg(araddr) ? RESP_OKAY : RESP_DECERR;
			s_d.rdata  = '0;
			unique case (1'b1)
				reg_hit(araddr, ACTIVE_PERIOD_IDX):     s_d.rdata[7:0] = s_q.active_period;
				reg_hit(araddr, INACTIVE_PERIOD_IDX):   s_d.rdata[7:0] = s_q.inactive_period;
				reg_hit(araddr, PULSE_COUNT_LOW_IDX):   s_d.rdata[7:0] = s_q.count_low;
				reg_hit(araddr, PULSE_COUNT_HIGH_IDX):  s_d.rdata[1:0] = s_q.count_high;
				reg_hit(araddr, MODULATOR_CONTROL_IDX): s_d.rdata[2:0] = s_q.control;
				reg_hit(araddr, IRQ_STATUS_IDX):        s_d.rdata[0]   = s_q.done_flag;
				reg_hit(araddr, IRQ_MASK_IDX):          s_d.rdata[0]   = s_q.done_mask;
				reg_hit(araddr, ENGINE_STATE_IDX): begin
					s_d.rdata[2:0]                 = s_q.phase;
					s_d.rdata[3]                   = s_q.out;
					s_d.rdata[8 +: COUNT_W]        = cnt_value;
				end
				default: s_d.rdata = '0;
			endcase
		end

		// --------------------------------------------------------
		// Pulse engine
		// --------------------------------------------------------
		unique case (s_q.phase)
			PHASE_IDLE: begin
				if (start) begin
					s_d.phase = PHASE_ACTIVE;
					tmr_load  = 1'b1;
					tmr_value = phase_load(s_q.active_period);
					cnt_load  = 1'b1;
				end
			end
			PHASE_ACTIVE: begin
				if (tmr_expired) begin
					if (long_pulse) begin
						// Off time ignored: one long low pulse of count active times
						cnt_dec = 1'b1;
						if (cnt_last) begin
							s_d.phase = PHASE_IDLE;
							set_done  = 1'b1;
						end else begin
							tmr_load  = 1'b1;
							tmr_value = phase_load(s_q.active_period);
						end
					end else if (pwm) begin
						// Continuous train; counter left alone
						s_d.phase = PHASE_INACTIVE;
						tmr_load  = 1'b1;
						tmr_value = phase_load(s_q.inactive_period);
					end else begin
						cnt_dec = 1'b1;
						if (cnt_last) begin
							s_d.phase = PHASE_IDLE;
							set_done  = 1'b1;
						end else begin
							s_d.phase = PHASE_INACTIVE;
							tmr_load  = 1'b1;
							tmr_value = phase_load(s_q.inactive_period);
						end
					end
				end
			end
			PHASE_INACTIVE: begin
				if (tmr_expired) begin
					s_d.phase = PHASE_ACTIVE;
					tmr_load  = 1'b1;
					tmr_value = phase_load(s_q.active_period);
				end
			end
			default: begin
				s_d.phase = PHASE_IDLE;
			end
		endcase

		// High-frequency carrier divider restarts with each active phase
		if (s_d.phase == PHASE_ACTIVE && (s_q.phase != PHASE_ACTIVE || tmr_load)) begin
			s_d.hf_div = '0;
		end else begin
			s_d.hf_div = s_q.hf_div + 1'b1;
		end

		// Output low while active, optionally chopped at a quarter of the clock
		if (s_d.phase == PHASE_ACTIVE) begin
			s_d.out = hf ? s_d.hf_div[HF_DIV_W-1] : 1'b0;
		end else begin
			s_d.out = 1'b1;
		end

		// New done wins over a clear in the same cycle
		s_d.done_flag = (s_q.done_flag && !clr_done) || set_done;
		s_d.irq       = s_d.done_flag && s_d.done_mask;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q                 <= '0;
			s_q.active_period   <= PERIOD_RESET;
			s_q.inactive_period <= PERIOD_RESET;
			s_q.count_low       <= COUNT_LOW_RESET;
			s_q.count_high      <= COUNT_HIGH_RESET;
			s_q.control         <= CONTROL_RESET;
			s_q.done_mask       <= MASK_RESET;
			s_q.done_flag       <= 1'b0;
			s_q.phase           <= PHASE_IDLE;
			s_q.out             <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign bvalid             = s_q.bvalid;
	assign bresp              = s_q.bresp;
	assign rvalid             = s_q.rvalid;
	assign rresp              = s_q.rresp;
	assign rdata              = s_q.rdata;
	assign ir_pulse_out       = s_q.out;
	assign modulator_done_irq = s_q.irq;
	assign watchdog_kick      = s_q.kick;

endmodule // ir_pulse_train_modulator

// ===== sim/ir_mod_monitor.sv
`timescale 1ns/1ps
module ir_mod_monitor import ir_mod_pkg::*; (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        ir_pulse_out,
	input wire logic        modulator_done_irq,
	input wire logic        watchdog_kick
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	chk_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
	chk_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped early");
	chk_ar_blocked: assert property (rvalid |-> !arready)
		else $error("read accepted while answer pending");
	// ------------------------------------------------------------
	// Pulse output
	// ------------------------------------------------------------
	// Both phases are the register value plus two, so never shorter than two
	chk_on_min_two: assert property ($fell(ir_pulse_out) |=> !ir_pulse_out)
		else $error("active phase shorter than two cycles");
	chk_off_min_two: assert property ($rose(ir_pulse_out) |=> ir_pulse_out)
		else $error("inactive phase shorter than two cycles");
	chk_stop_on_flag: assert property (modulator_done_irq |-> ir_pulse_out)
		else $error("output active while done flag raised");
	chk_flag_clear_write: assert property ($fell(modulator_done_irq) |-> $rose(bvalid))
		else $error("interrupt dropped without a write");
	chk_kick_single: assert property (watchdog_kick |=> !watchdog_kick)
		else $error("watchdog kick longer than one cycle");
	chk_kick_cause: assert property (watchdog_kick |-> bvalid || $past(bvalid))
		else $error("watchdog kick without a write");
	cov_train_done: cover property ($rose(modulator_done_irq));
	cov_kick: cover property (watchdog_kick);
	cov_decerr: cover property (bvalid && bresp == RESP_DECERR);
endmodule // ir_mod_monitor

bind ir_pulse_train_modulator ir_mod_monitor ir_mod_monitor_i (
	.clock(clock), .rst_n(rst_n), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.ir_pulse_out(ir_pulse_out), .modulator_done_irq(modulator_done_irq),
	.watchdog_kick(watchdog_kick)
);

// ===== sim/ir_led_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Infrared emitter: lit while the pin is low, measures each level
// ------------------------------------------------------------
module ir_led_model (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic ir_pulse_out,
	output int        pulses,
	output int        last_on,
	output int        last_off
);
	logic prev_q;
	int   run_q;
	// Widths in whole clocks, so a phase off by one shows directly
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 1'b1;
			run_q <= 0;
			pulses <= 0;
			last_on <= 0;
			last_off <= 0;
		end else if (ir_pulse_out === prev_q) begin
			run_q <= run_q + 1;
		end else begin
			run_q <= 1;
			prev_q <= ir_pulse_out;
			if (prev_q === 1'b0) begin
				pulses <= pulses + 1;
				last_on <= run_q;
			end else begin
				last_off <= run_q;
			end
		end
	end
endmodule // ir_led_model

// ===== sim/tb_ir_pulse_train_modulator.sv
`timescale 1ns/1ps
module tb_ir_pulse_train_modulator import ir_mod_pkg::*;;
	logic        clock = 1'b0, rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        bready = 1'b1, rready = 1'b1;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        ir_pulse_out, modulator_done_irq, watchdog_kick;
	int          pulses, last_on, last_off, kicks = 0, cyc = 0;
	int          n_fail = 0, checks_done = 0;
	always #25 clock = ~clock;
	ir_pulse_train_modulator ir_pulse_train_modulator_i (
		.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ir_pulse_out(ir_pulse_out), .modulator_done_irq(modulator_done_irq),
		.watchdog_kick(watchdog_kick));
	ir_led_model ir_led_model_i (.clock(clock), .rst_n(rst_n), .ir_pulse_out(ir_pulse_out),
		.pulses(pulses), .last_on(last_on), .last_off(last_off));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task wrap_up;
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard: whole run is well under this
	always @(posedge clock) begin
		cyc++;
		if (watchdog_kick === 1'b1) kicks++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	// Handshake decided at the negedge before the taking edge: inputs only move at posedge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit pa, pw, ta, tw;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		pa = 1;
		pw = 1;
		while (pa || pw) begin
			@(negedge clock);
			ta = pa && awready === 1'b1;
			tw = pw && wready === 1'b1;
			@(posedge clock);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do @(negedge clock); while (bvalid !== 1'b1);
		chk("bresp", er, bresp);
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		bit t;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clock);
			t = arready === 1'b1;
			@(posedge clock);
		end while (!t);
		arvalid <= 1'b0;
		do @(negedge clock); while (rvalid !== 1'b1);
		chk("rdata", e, rdata);
		chk("rresp", er, rresp);
		@(posedge clock);
	endtask
	task automatic wait_irq;
		int k;
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (modulator_done_irq !== 1'b1 && k < 3000);
		chk("irq_raised", 1, modulator_done_irq);
	endtask
	task automatic run_train(input logic [7:0] on, off, input logic [9:0] n,
		input logic [31:0] ctl, input int e_on, e_off, e_p);
		int p0;
		p0 = pulses;
		wr(8'h0c, ctl | 32'h8, RESP_OKAY);
		wr(8'h00, {24'h0, on}, RESP_OKAY);
		wr(8'h04, {24'h0, off}, RESP_OKAY);
		wr(8'h10, {30'h0, n[9:8]}, RESP_OKAY);
		wr(8'h08, {24'h0, n[7:0]}, RESP_OKAY);
		@(negedge clock);
		if (!ctl[0]) chk("started_low", 0, ir_pulse_out);
		wait_irq();
		@(posedge clock);
		@(negedge clock);
		if (e_p >= 0) chk("pulse_count", e_p, pulses - p0);
		chk("on_width", e_on, last_on);
		if (e_off > 0) chk("off_width", e_off, last_off);
		chk("idle_high", 1, ir_pulse_out);
		@(posedge clock);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		@(negedge clock);
		chk("reset_out", 1, ir_pulse_out);
		chk("reset_irq", 0, modulator_done_irq);
		@(posedge clock);
		rd(8'h00, 32'h0, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_OKAY);
		rd(8'h18, 32'h1, RESP_OKAY);
		rd(8'h1c, 32'h9, RESP_OKAY);
	endtask
	task automatic t_regs;
		wr(8'h00, 32'ha5, RESP_OKAY);
		rd(8'h00, 32'ha5, RESP_OKAY);
		wr(8'h04, 32'h3c, RESP_OKAY);
		rd(8'h04, 32'h3c, RESP_OKAY);
		wr(8'h10, 32'hff, RESP_OKAY);
		rd(8'h10, 32'h3, RESP_OKAY);
		wr(8'h0c, 32'h07, RESP_OKAY);
		rd(8'h0c, 32'h07, RESP_OKAY);
		wr(8'h20, 32'h1, RESP_DECERR);
		rd(8'h20, 32'h0, RESP_DECERR);
		// Answers held back by the master must stand until taken
		bready <= 1'b0;
		rready <= 1'b0;
		wr(8'h00, 32'h5a, RESP_OKAY);
		rd(8'h00, 32'h5a, RESP_OKAY);
		repeat (3) @(negedge clock);
		chk("bvalid_held", 1, bvalid);
		chk("rvalid_held", 1, rvalid);
		chk("rdata_held", 32'h5a, rdata);
		@(posedge clock);
		bready <= 1'b1;
		rready <= 1'b1;
		@(posedge clock);
	endtask
	task automatic t_blocked;
		int k0;
		bit stay;
		k0 = kicks;
		stay = 1;
		wr(8'h08, 32'h1, RESP_OKAY);
		repeat (20) begin
			@(negedge clock);
			if (ir_pulse_out !== 1'b1) stay = 0;
		end
		chk("no_restart", 1, stay);
		@(posedge clock);
		wr(8'h0c, 32'h18, RESP_OKAY);
		repeat (3) @(negedge clock);
		chk("flag_cleared", 0, modulator_done_irq);
		chk("kick_seen", 1, kicks - k0);
		@(posedge clock);
	endtask
	task automatic t_mask;
		wr(8'h18, 32'h0, RESP_OKAY);
		wr(8'h0c, 32'h8, RESP_OKAY);
		wr(8'h10, 32'h0, RESP_OKAY);
		wr(8'h08, 32'h1, RESP_OKAY);
		repeat (30) @(negedge clock);
		chk("masked_irq", 0, modulator_done_irq);
		@(posedge clock);
		rd(8'h14, 32'h1, RESP_OKAY);
		wr(8'h18, 32'h1, RESP_OKAY);
		@(negedge clock);
		chk("unmasked_irq", 1, modulator_done_irq);
		@(posedge clock);
		wr(8'h14, 32'h1, RESP_OKAY);
		@(negedge clock);
		chk("w1c_irq", 0, modulator_done_irq);
		@(posedge clock);
		rd(8'h14, 32'h0, RESP_OKAY);
	endtask
	task automatic t_pwm;
		int p0;
		p0 = pulses;
		wr(8'h0c, 32'h0c, RESP_OKAY);
		wr(8'h08, 32'h1, RESP_OKAY);
		repeat (200) @(negedge clock);
		chk("pwm_no_done", 0, modulator_done_irq);
		chk("pwm_running", 1, (pulses - p0) > 10);
		@(posedge clock);
		wr(8'h0c, 32'h0, RESP_OKAY);
		wait_irq();
		@(posedge clock);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_regs();
		run_train(8'd3, 8'd5, 10'd3, 32'h0, 5, 7, 3);
		t_blocked();
		// Upper count bits and the shortest phases together
		run_train(8'd0, 8'd0, 10'h102, 32'h0, 2, 2, 258);
		run_train(8'd9, 8'd0, 10'd1, 32'h1, 2, 0, -1);
		run_train(8'd1, 8'd7, 10'd4, 32'h2, 12, 0, 1);
		t_mask();
		t_pwm();
		wrap_up();
	end
endmodule // tb_ir_pulse_train_modulator
